/* hdl/i2cm_regs.svh */
`ifndef I2CM_REGS_SVH
`define I2CM_REGS_SVH
// ==========================================
// register offsets (byte addresses)
`define I2CM_OFS_CTRL 4'h0
`define I2CM_OFS_RXDATA 4'h4
`define I2CM_OFS_STATUS 4'h8
`define I2CM_OFS_TXDATA 4'hc
// ==========================================
// bus_control field positions
`define I2CM_BIT_START 0
`define I2CM_BIT_RESTART 1
`define I2CM_BIT_STOP 2
`define I2CM_BIT_RECV 3
`define I2CM_BIT_ACKGO 4
`define I2CM_BIT_ACKVAL 5
`define I2CM_CTRL_RESET 6'h00
// ==========================================
// status and rxdata field positions
`define I2CM_ST_BUSY 0
`define I2CM_ST_ACKRX 1
`define I2CM_ST_TXGO 2
`define I2CM_ST_CNT_LSB 8
`define I2CM_RX_VALID 8
// ==========================================
// timing: quarter of the serial clock period
`define I2CM_CLK_MHZ 100
`define I2CM_T_QTR_NS 2500
`define I2CM_QTR_CYC ((`I2CM_T_QTR_NS * `I2CM_CLK_MHZ) / 1000)
`endif

/* hdl/i2cm_pkg.sv */
package i2cm_pkg;
  typedef enum logic [2:0] {
    I2CM_S_IDLE,
    I2CM_S_START,
    I2CM_S_RSTART,
    I2CM_S_STOP,
    I2CM_S_RX,
    I2CM_S_ACK,
    I2CM_S_TX
  } i2cm_state_t;
endpackage

/* hdl/i2cm_ctrl.sv */
`timescale 1ns/10ps
// What this block does
// - ack slot drives ack_value_select: 1 gives NACK, 0 gives ACK.
// - ack_sequence_go runs an acknowledge sequence, cleared by hardware at its end.
// - byte_receive_go clocks in one byte, cleared after the eighth bit.
// - stop_sequence_go makes a Stop condition, cleared by hardware when done.
// - restart_sequence_go makes a Repeated Start, cleared by hardware when done.
// - start_sequence_go makes a Start condition, cleared by hardware when done.
`include "i2cm_regs.svh"

// ==========================================
// receive byte fifo
module i2cm_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic push;
  logic pop;

  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != '0);
  assign out_data = mem[rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule

// ==========================================
// master sequence controller with avalon slave
module i2cm_ctrl
  import i2cm_pkg::*;
#(
  parameter int FIFO_DEPTH = 32
) (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic serial_clock_pin_in,
  output logic serial_clock_pin_out,
  output logic serial_clock_pin_oe,
  input wire logic serial_data_pin_in,
  output logic serial_data_pin_out,
  output logic serial_data_pin_oe
);
  localparam logic [15:0] QTR = 16'(`I2CM_QTR_CYC);
  localparam int CW = $clog2(FIFO_DEPTH) + 1;

  i2cm_state_t state;
  logic [1:0] step;
  logic [3:0] bit_idx;
  logic [15:0] qcnt;
  logic [7:0] rx_shift;
  logic [7:0] tx_shift;
  logic [5:0] ctrl;
  logic tx_go;
  logic ack_received;
  logic scl_s1, scl_s2, sda_s1, sda_s2;
  logic tick, stretch, last_bit, seq_end, hold_full;
  logic next_scl_oe, next_sda_oe;
  logic acc_wr, acc_rd;
  logic fifo_in_ready, fifo_out_valid, fifo_pop;
  logic [7:0] fifo_out_data;
  logic [CW-1:0] fifo_count;

  // ==========================================
  // pin synchronisers
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
    end else begin
      scl_s1 <= serial_clock_pin_in;
      scl_s2 <= scl_s1;
      sda_s1 <= serial_data_pin_in;
      sda_s2 <= sda_s1;
    end
  end

  // ==========================================
  // quarter-period timing, held while a slave stretches the clock
  assign stretch = !serial_clock_pin_oe && !scl_s2;
  assign tick = (state != I2CM_S_IDLE) && (qcnt == QTR - 16'd1) && !stretch;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      qcnt <= '0;
    end else if (state == I2CM_S_IDLE || tick) begin
      qcnt <= '0;
    end else if (!stretch) begin
      qcnt <= qcnt + 16'd1;
    end
  end

  // ==========================================
  // sequence engine
  always_comb begin
    case (state)
      I2CM_S_RX: last_bit = (bit_idx == 4'd7);
      I2CM_S_TX: last_bit = (bit_idx == 4'd8);
      default: last_bit = 1'b1;
    endcase
  end

  // a full fifo holds the clock low in step 3 of whichever bit is being received
  assign hold_full = (state == I2CM_S_RX) && !fifo_in_ready;
  assign seq_end = tick && (step == 2'd3) && last_bit && !hold_full;

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state <= I2CM_S_IDLE;
      step <= 2'd0;
      bit_idx <= 4'd0;
    end else begin
      case (state)
        I2CM_S_IDLE: begin
          step <= 2'd0;
          bit_idx <= 4'd0;
          if (ctrl[`I2CM_BIT_START]) begin
            state <= I2CM_S_START;
          end else if (ctrl[`I2CM_BIT_RESTART]) begin
            state <= I2CM_S_RSTART;
          end else if (ctrl[`I2CM_BIT_STOP]) begin
            state <= I2CM_S_STOP;
          end else if (ctrl[`I2CM_BIT_ACKGO]) begin
            state <= I2CM_S_ACK;
          end else if (ctrl[`I2CM_BIT_RECV]) begin
            state <= I2CM_S_RX;
          end else if (tx_go) begin
            state <= I2CM_S_TX;
          end
        end
        default: begin
          if (seq_end) begin
            state <= I2CM_S_IDLE;
          end else if (tick && !(step == 2'd3 && hold_full)) begin
            step <= step + 2'd1;
            if (step == 2'd3) begin
              bit_idx <= bit_idx + 4'd1;
            end
          end
        end
      endcase
    end
  end

  // ==========================================
  // pin levels per state and quarter step
  always_comb begin
    next_scl_oe = serial_clock_pin_oe;
    next_sda_oe = serial_data_pin_oe;
    case (state)
      I2CM_S_START: begin
        next_scl_oe = (step == 2'd3);
        next_sda_oe = (step != 2'd0);
      end
      I2CM_S_RSTART: begin
        next_scl_oe = (step == 2'd0) || (step == 2'd3);
        next_sda_oe = (step >= 2'd2);
      end
      I2CM_S_STOP: begin
        next_scl_oe = (step == 2'd0);
        next_sda_oe = (step <= 2'd1);
      end
      I2CM_S_RX, I2CM_S_ACK, I2CM_S_TX: begin
        next_scl_oe = (step == 2'd0) || (step == 2'd3);
        if (state == I2CM_S_ACK) begin
          next_sda_oe = !ctrl[`I2CM_BIT_ACKVAL];
        end else if (state == I2CM_S_TX && bit_idx != 4'd8) begin
          next_sda_oe = !tx_shift[7];
        end else begin
          next_sda_oe = 1'b0;
        end
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      serial_clock_pin_oe <= 1'b0;
      serial_data_pin_oe <= 1'b0;
      serial_clock_pin_out <= 1'b0;
      serial_data_pin_out <= 1'b0;
    end else begin
      serial_clock_pin_oe <= next_scl_oe;
      serial_data_pin_oe <= next_sda_oe;
      serial_clock_pin_out <= 1'b0;
      serial_data_pin_out <= 1'b0;
    end
  end

  // ==========================================
  // data sampling in the high half of each bit
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rx_shift <= 8'h00;
      ack_received <= 1'b0;
    end else if (tick && step == 2'd2) begin
      if (state == I2CM_S_RX) begin
        rx_shift <= {rx_shift[6:0], sda_s2};
      end else if (state == I2CM_S_TX && bit_idx == 4'd8) begin
        ack_received <= !sda_s2;
      end
    end
  end

  // ==========================================
  // avalon handshake: request taken on the second edge
  assign acc_wr = avs_write && !avs_waitrequest;
  assign acc_rd = avs_read && !avs_waitrequest;
  assign fifo_pop = acc_rd && (avs_address == `I2CM_OFS_RXDATA);

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      case (avs_address)
        `I2CM_OFS_CTRL: avs_readdata <= {26'h0, ctrl};
        `I2CM_OFS_RXDATA: avs_readdata <= {23'h0, fifo_out_valid, fifo_out_data};
        `I2CM_OFS_STATUS: avs_readdata <= {(24 - CW)'(0), fifo_count, 5'h00, tx_go, ack_received,
                                           state != I2CM_S_IDLE};
        `I2CM_OFS_TXDATA: avs_readdata <= {24'h0, tx_shift};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================
  // command bits: hardware clears at sequence end, a ctrl write with byteenable[0] in that same cycle wins
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      ctrl <= `I2CM_CTRL_RESET;
    end else begin
      if (seq_end) begin
        case (state)
          I2CM_S_START: ctrl[`I2CM_BIT_START] <= 1'b0;
          I2CM_S_RSTART: ctrl[`I2CM_BIT_RESTART] <= 1'b0;
          I2CM_S_STOP: ctrl[`I2CM_BIT_STOP] <= 1'b0;
          I2CM_S_ACK: ctrl[`I2CM_BIT_ACKGO] <= 1'b0;
          I2CM_S_RX: ctrl[`I2CM_BIT_RECV] <= 1'b0;
          default: begin
          end
        endcase
      end
      if (acc_wr && avs_address == `I2CM_OFS_CTRL && avs_byteenable[0]) begin
        ctrl[`I2CM_BIT_ACKVAL] <= avs_writedata[`I2CM_BIT_ACKVAL];
        ctrl[4:0] <= ctrl[4:0] | avs_writedata[4:0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      tx_go <= 1'b0;
      tx_shift <= 8'h00;
    end else begin
      if (seq_end && state == I2CM_S_TX) begin
        tx_go <= 1'b0;
      end else if (state == I2CM_S_TX && tick && step == 2'd3) begin
        tx_shift <= {tx_shift[6:0], 1'b0};
      end
      if (acc_wr && avs_address == `I2CM_OFS_TXDATA && avs_byteenable[0] && state == I2CM_S_IDLE) begin
        tx_go <= 1'b1;
        tx_shift <= avs_writedata[7:0];
      end
    end
  end

  i2cm_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .in_data(rx_shift),
    .in_valid(seq_end && state == I2CM_S_RX),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .count(fifo_count)
  );

  // ==========================================
  // checks
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  sequence s_start_clr;
    $fell(ctrl[`I2CM_BIT_START]);
  endsequence
  sequence s_ack_slot;
    state == I2CM_S_ACK && step == 2'd2 ##1 1'b1;
  endsequence

  AST_ACK_LEVEL: assert property (s_ack_slot |-> serial_data_pin_oe == !$past(ctrl[`I2CM_BIT_ACKVAL]))
    else $error("ack slot level differs from ack_value_select");
  AST_ACK_CLEAR: assert property ($fell(ctrl[`I2CM_BIT_ACKGO]) |-> $past(state) == I2CM_S_ACK)
    else $error("ack_sequence_go cleared outside an ack sequence");
  AST_RX_CLEAR: assert property ($fell(ctrl[`I2CM_BIT_RECV]) |-> $past(bit_idx) == 4'd7 && $past(fifo_in_ready))
    else $error("byte_receive_go cleared before the eighth bit");
  AST_STOP_PINS: assert property ($fell(ctrl[`I2CM_BIT_STOP]) |-> ##1 !serial_data_pin_oe && !serial_clock_pin_oe)
    else $error("stop did not release both lines");
  AST_RSTART_PINS: assert property ($fell(ctrl[`I2CM_BIT_RESTART]) |-> ##1 serial_data_pin_oe && serial_clock_pin_oe)
    else $error("repeated start did not leave both lines low");
  AST_START_PINS: assert property (s_start_clr |-> ##1 serial_data_pin_oe && serial_clock_pin_oe)
    else $error("start did not leave both lines low");
  AST_START_SDA_FIRST: assert property (state == I2CM_S_START && step == 2'd2 |-> serial_data_pin_oe)
    else $error("start pulled clock before data");
  AST_STOP_SDA_LAST: assert property (state == I2CM_S_STOP && step == 2'd2 |-> ##1 !serial_clock_pin_oe)
    else $error("stop released data while clock low");
endmodule

/* tb/i2cm_slave_model.sv */
`timescale 1ns/10ps
// ==========================================
// slave device on the two-wire bus
module i2cm_slave_model (
  input wire logic scl,
  input wire logic sda,
  input wire logic [7:0] tx_byte,
  input wire logic tx_en,
  input wire logic stretch,
  output logic sda_oe,
  output logic scl_oe,
  output int start_cnt,
  output int stop_cnt,
  output logic ack_seen
);
  int idx = 9;
  initial begin
    sda_oe = 1'b0;
    scl_oe = 1'b0;
    start_cnt = 0;
    stop_cnt = 0;
    ack_seen = 1'b0;
  end
  // ==========================================
  // conditions: data moves while clock high, known levels only
  logic sda_q = 1'b1;
  always @(sda) begin
    if (scl === 1'b1 && sda_q === 1'b1 && sda === 1'b0) start_cnt++;
    if (scl === 1'b1 && sda_q === 1'b0 && sda === 1'b1) stop_cnt++;
    sda_q = sda;
  end
  // ==========================================
  // byte out, msb first, changed while clock low
  always @(posedge tx_en) begin
    idx = 1;
    sda_oe = ~tx_byte[7];
  end
  always @(negedge scl) begin
    if (tx_en && idx < 8) begin
      sda_oe = ~tx_byte[7 - idx];
      idx = idx + 1;
    end else if (idx == 8) begin
      sda_oe = 1'b0;
      idx = 9;
    end
    // slow slave holds the clock low past the master's own low time
    if (stretch) begin
      scl_oe = 1'b1;
      #7500;
      scl_oe = 1'b0;
    end
  end
  always @(posedge scl) ack_seen = sda;
endmodule

/* tb/tb.sv */
`timescale 1ns/10ps
// ==========================================
// bench top
module tb;
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic scl_out, scl_oe, sda_out, sda_oe, slv_sda_oe, slv_scl_oe, ack_seen;
  logic [7:0] tx_byte = 8'h00;
  logic tx_en = 1'b0;
  logic stretch = 1'b0;
  int start_cnt, stop_cnt;
  int err_total = 0;
  int checks_done = 0;
  logic [31:0] q;
  // open drain lines with pull-up
  wire scl_line = ~(scl_oe | slv_scl_oe);
  wire sda_line = ~(sda_oe | slv_sda_oe);

  always #5 clk_sys = ~clk_sys;

  i2cm_ctrl i_i2cm_ctrl (.clk_sys(clk_sys), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .serial_clock_pin_in(scl_line), .serial_clock_pin_out(scl_out), .serial_clock_pin_oe(scl_oe),
    .serial_data_pin_in(sda_line), .serial_data_pin_out(sda_out), .serial_data_pin_oe(sda_oe));

  i2cm_slave_model i_i2cm_slave_model (.scl(scl_line), .sda(sda_line), .tx_byte(tx_byte),
    .tx_en(tx_en), .stretch(stretch), .sda_oe(slv_sda_oe), .scl_oe(slv_scl_oe),
    .start_cnt(start_cnt), .stop_cnt(stop_cnt), .ack_seen(ack_seen));

  // ==========================================
  // access tasks
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask

  // one command at a time, next only after the clear
  task automatic go(input logic [31:0] d, input logic [31:0] mask);
    int n;
    n = 0;
    bus(1'b1, 4'h0, d);
    q = mask;
    while ((q & mask) != 0 && n < 5000) begin
      bus(1'b0, 4'h0, 32'h0);
      n++;
    end
    chk("go bit clear", q & mask, 32'h0);
  endtask

  task automatic results;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ==========================================
  // watchdog
  initial begin
    #600000;
    err_total++;
    results();
  end

  // ==========================================
  // tests
  initial begin
    repeat (8) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    bus(1'b0, 4'h0, 32'h0);
    chk("ctrl reset", q, 32'h0);
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped read", q, 32'h0);
    go(32'h01, 32'h01);
    chk("start count", start_cnt, 32'h1);
    chk("lines after start", {30'h0, scl_line, sda_line}, 32'h0);
    tx_byte <= 8'ha5;
    tx_en <= 1'b1;
    stretch <= 1'b1;
    go(32'h08, 32'h08);
    bus(1'b0, 4'h8, 32'h0);
    chk("fifo count", {26'h0, q[13:8]}, 32'h1);
    bus(1'b0, 4'h4, 32'h0);
    chk("rx byte", q, 32'h000001a5);
    tx_en <= 1'b0;
    stretch <= 1'b0;
    go(32'h30, 32'h10);
    chk("nack sent", {31'h0, ack_seen}, 32'h1);
    bus(1'b0, 4'h0, 32'h0);
    chk("ack select kept", q, 32'h20);
    go(32'h10, 32'h10);
    chk("ack sent", {31'h0, ack_seen}, 32'h0);
    go(32'h02, 32'h02);
    chk("restart count", start_cnt, 32'h2);
    chk("lines after restart", {30'h0, scl_line, sda_line}, 32'h0);
    // transmit one byte, slave leaves the ack slot released
    bus(1'b1, 4'hc, 32'h5a);
    q = 32'h4;
    for (int n = 0; n < 5000 && (q & 32'h4) != 0; n++) begin
      bus(1'b0, 4'h8, 32'h0);
    end
    chk("status after transmit", q & 32'h3f07, 32'h0);
    chk("transmit ack slot", {31'h0, ack_seen}, 32'h1);
    chk("start count after transmit", start_cnt, 32'h2);
    go(32'h04, 32'h04);
    chk("stop count", stop_cnt, 32'h1);
    chk("lines after stop", {30'h0, scl_line, sda_line}, 32'h3);
    chk("pin out levels", {30'h0, scl_out, sda_out}, 32'h0);
    results();
  end
endmodule
